// >>> rtl/kl_lock_ctrl.sv
/*
 * kl_lock_ctrl: keypad lock/unlock, lock interrupt mask timer, three-key
 * combination, port change interrupt, open-drain interrupt pin with
 * optional release pulse, idle/active scan mode and the event store.
 * assumes key events come from a scanner on the same clock, one per
 * cycle at most, and that rows and port pins are asynchronous pins.
 */
// How it works
// [RULE_01] lock bit suppresses key interrupts and recording
// [RULE_02] any event table code may be unlock key
// [RULE_03] nonzero mask: unlock keys needed before events
// [RULE_04] first press while locked raises key interrupt
// [RULE_05] lock interrupt on ordered keys, else restart
// [RULE_06] unlock time limit in timer bits 2:0
// [RULE_07] mask seconds in timer bits 7:3, zero disables
// [RULE_08] lock bit write one locks, zero unlocks
// [RULE_09] mask countdown only when locked and nonzero
// [RULE_10] press after expiry interrupts and restarts countdown
// [RULE_11] keys 1, 11, 21 held raise combination flag
// [RULE_12] input port change interrupts until restored or read
// [RULE_13] output pins and foreign traffic never interrupt
// [RULE_14] interrupt pin open drain, active low
// [RULE_15] pulse bit: clearing pending flag releases 50 us
// [RULE_16] reset sets every register to default
// [RULE_17] idle: columns low, rows pulled up, oscillator off
// [RULE_18] low row starts active scan until release
// [RULE_19] host starts transfers only on idle bus
// [RULE_20] host read: start, address, index, data, stop
// [RULE_21] event byte: bit 7 press, low bits code
// [RULE_22] gating bit drops switch events while locked
// [RULE_23] timers count second ticks, oscillator kept running
`default_nettype none

module kl_lock_ctrl #(
	parameter int TICK_CYCLES = kl_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// register port
	input wire kl_pkg::kl_bus_t bus,
	output logic [7:0] rdata_q,
	// key events from the scanner
	input wire kl_pkg::kl_event_t key_ev,
	input wire logic scan_released,
	// keypad matrix pins
	input wire logic [7:0] row_pins,
	output logic col_drive_low_q,
	output logic row_pullup_q,
	output logic osc_en_q,
	// general port pins
	input wire logic [7:0] port_pins,
	// interrupt pin, open drain
	output logic int_n_o,
	output logic int_n_oe_q
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] off);
		hit = strobe && (addr == off);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] cfg_q;
	logic [4:0] int_stat_q, int_stat_d, ist_set, ist_clr;
	logic lock_en_q, lock_en_d;
	logic [7:0] first_unlock_key_q, second_unlock_key_q, lock_tmr_q, port_dir_q;
	logic sw_gate_q;
	logic [7:0] ev_mem_q [kl_pkg::EV_DEPTH];
	logic [3:0] ev_cnt_q;
	logic [7:0] row_s1_q, row_s2_q, port_s1_q, port_s2_q, port_ref_q;
	logic [1:0] init_cnt_q;
	logic [2:0] held_q, held_d;
	logic [4:0] mask_cnt_q;
	logic [2:0] ul_cnt_q;
	logic [25:0] tick_cnt_q;
	logic [11:0] pulse_cnt_q;
	kl_pkg::kl_scan_t scan_q;
	kl_pkg::kl_unlock_t ul_q, ul_d;
	logic wr, rd, ev_ok, press_ok, record, tick, timers_on;
	logic mask_on, mask_load, mask_expire, ul_expire, unlocked_now;
	logic push, pop, port_irq, pending, pulse_start;
	logic [7:0] ev_byte;

	assign wr = bus.wr && ce;
	assign rd = bus.rd && ce;
	assign int_n_o = 1'b0; // the pin is only ever pulled low, see [RULE_14]

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// rows and port pins are asynchronous, two flops before use
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			row_s1_q <= 8'hff;
			row_s2_q <= 8'hff;
			port_s1_q <= 8'h00;
			port_s2_q <= 8'h00;
		end else if (ce) begin
			row_s1_q <= row_pins;
			row_s2_q <= row_s1_q;
			port_s1_q <= port_pins;
			port_s2_q <= port_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// key event qualification and lock decisions
	// ----------------------------------------------------------------
	// switch events are dropped while locked with gating on
	assign ev_ok = ce && key_ev.valid &&
		!(key_ev.is_switch && sw_gate_q && lock_en_q); // see [RULE_22]
	assign press_ok = ev_ok && key_ev.press;
	// nothing is recorded while locked, except ungated switch events
	assign record = ev_ok &&
		(!lock_en_q || key_ev.is_switch); // see [RULE_01] see [RULE_22]
	assign ev_byte = {key_ev.press, key_ev.code}; // see [RULE_21]
	assign mask_on = lock_en_q &&
		(lock_tmr_q[7:3] != 5'h00); // see [RULE_07] see [RULE_09]
	// a locked press with a nonzero mask and the countdown idle interrupts and reloads it
	assign mask_load = mask_on && press_ok &&
		(mask_cnt_q == 5'h00); // see [RULE_04] see [RULE_10]
	assign mask_expire = mask_on && tick && (mask_cnt_q == 5'h01);
	assign ul_expire = (ul_q == kl_pkg::KL_UL_SECOND) && tick &&
		(lock_tmr_q[2:0] != 3'h0) && (ul_cnt_q == 3'h1); // see [RULE_06]

	// ----------------------------------------------------------------
	// unlock sequence
	// ----------------------------------------------------------------
	// any code is compared, so matrix and switch codes both qualify
	always_comb begin
		ul_d = ul_q;
		unlocked_now = 1'b0;
		if (!lock_en_q) begin
			ul_d = kl_pkg::KL_UL_FIRST;
		end else if (press_ok) begin
			case (ul_q)
				kl_pkg::KL_UL_FIRST: begin
					if (key_ev.code == first_unlock_key_q[6:0]) begin // see [RULE_02]
						ul_d = kl_pkg::KL_UL_SECOND;
					end
				end
				kl_pkg::KL_UL_SECOND: begin
					if (key_ev.code == second_unlock_key_q[6:0]) begin
						unlocked_now = 1'b1; // see [RULE_05] see [RULE_03]
						ul_d = kl_pkg::KL_UL_FIRST;
					end else if (key_ev.code != first_unlock_key_q[6:0]) begin
						ul_d = kl_pkg::KL_UL_FIRST; // wrong order, start over
					end
				end
				default: ul_d = kl_pkg::KL_UL_FIRST;
			endcase
		end else if (ul_expire || mask_expire) begin
			ul_d = kl_pkg::KL_UL_FIRST; // see [RULE_05]
		end
	end

	// unlock state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ul_q <= kl_pkg::KL_UL_FIRST;
		end else if (ce) begin
			ul_q <= ul_d;
		end
	end

	// unlock window counter, reloaded on every first key
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ul_cnt_q <= 3'h0;
		end else if (ce) begin
			if (press_ok && lock_en_q && key_ev.code == first_unlock_key_q[6:0]) begin
				ul_cnt_q <= lock_tmr_q[2:0]; // see [RULE_06]
			end else if (ul_q == kl_pkg::KL_UL_FIRST) begin
				ul_cnt_q <= 3'h0;
			end else if (tick && ul_cnt_q != 3'h0) begin
				ul_cnt_q <= ul_cnt_q - 3'h1;
			end
		end
	end

	// mask countdown in seconds
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask_cnt_q <= 5'h00;
		end else if (ce) begin
			if (!mask_on) begin
				mask_cnt_q <= 5'h00; // see [RULE_09]
			end else if (mask_load) begin
				mask_cnt_q <= lock_tmr_q[7:3]; // see [RULE_10]
			end else if (tick && mask_cnt_q != 5'h00) begin
				mask_cnt_q <= mask_cnt_q - 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// second tick
	// ----------------------------------------------------------------
	// the divider only runs while a timer needs it, saving power
	assign timers_on = (mask_cnt_q != 5'h00) ||
		(ul_q == kl_pkg::KL_UL_SECOND);
	assign tick = ce && timers_on &&
		(tick_cnt_q == 26'(TICK_CYCLES - 1)); // see [RULE_23]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_q <= 26'h0;
		end else if (ce) begin
			if (!timers_on || tick || mask_load) begin
				tick_cnt_q <= 26'h0;
			end else begin
				tick_cnt_q <= tick_cnt_q + 26'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// three-key combination
	// ----------------------------------------------------------------
	always_comb begin
		held_d = held_q;
		if (ev_ok && !key_ev.is_switch) begin
			if (key_ev.code == kl_pkg::KEY_A) begin
				held_d[0] = key_ev.press;
			end
			if (key_ev.code == kl_pkg::KEY_B) begin
				held_d[1] = key_ev.press;
			end
			if (key_ev.code == kl_pkg::KEY_C) begin
				held_d[2] = key_ev.press;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			held_q <= 3'h0;
		end else if (ce) begin
			held_q <= held_d;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and lock bit
	// ----------------------------------------------------------------
	always_comb begin
		ist_set = 5'h00;
		ist_set[kl_pkg::IST_KEY] = (record && !key_ev.is_switch) ||
			mask_load; // see [RULE_04]
		ist_set[kl_pkg::IST_SW] = record && key_ev.is_switch;
		ist_set[kl_pkg::IST_LOCK] = unlocked_now; // see [RULE_05]
		ist_set[kl_pkg::IST_THREE] = (&held_d) && !(&held_q); // see [RULE_11]
		ist_clr = 5'h00;
		if (hit(wr, bus.addr, kl_pkg::ADR_INT_STAT)) begin
			ist_clr = bus.wdata[4:0] & kl_pkg::IST_WMASK;
		end
		// a new event wins over a clear in the same cycle
		int_stat_d = (int_stat_q & ~ist_clr) | ist_set;
	end

	// host write wins over a hardware unlock in the same cycle
	always_comb begin
		lock_en_d = lock_en_q;
		if (unlocked_now) begin
			lock_en_d = 1'b0;
		end
		if (hit(wr, bus.addr, kl_pkg::ADR_LOCK_EC)) begin
			lock_en_d = bus.wdata[kl_pkg::LEC_LOCK_EN]; // see [RULE_08]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			int_stat_q <= 5'h00;
			lock_en_q <= 1'b0;
		end else if (ce) begin
			int_stat_q <= int_stat_d;
			lock_en_q <= lock_en_d;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= kl_pkg::RST_REG; // see [RULE_16]
			first_unlock_key_q <= kl_pkg::RST_REG;
			second_unlock_key_q <= kl_pkg::RST_REG;
			lock_tmr_q <= kl_pkg::RST_REG;
			port_dir_q <= kl_pkg::RST_REG;
			sw_gate_q <= 1'b0;
		end else if (ce) begin
			if (hit(wr, bus.addr, kl_pkg::ADR_CFG)) begin
				cfg_q <= bus.wdata;
			end else if (hit(wr, bus.addr, kl_pkg::ADR_FIRST_UNLOCK_KEY)) begin
				first_unlock_key_q <= {1'b0, bus.wdata[6:0]};
			end else if (hit(wr, bus.addr, kl_pkg::ADR_SECOND_UNLOCK_KEY)) begin
				second_unlock_key_q <= {1'b0, bus.wdata[6:0]};
			end else if (hit(wr, bus.addr, kl_pkg::ADR_LOCK_TMR)) begin
				lock_tmr_q <= bus.wdata;
			end else if (hit(wr, bus.addr, kl_pkg::ADR_PORT_DIR)) begin
				port_dir_q <= bus.wdata;
			end else if (hit(wr, bus.addr, kl_pkg::ADR_SW_GATE)) begin
				sw_gate_q <= bus.wdata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// event store
	// ----------------------------------------------------------------
	// a full store drops new events; no overflow flag is kept
	assign push = record && (ev_cnt_q != kl_pkg::EV_FULL);
	assign pop = hit(rd, bus.addr, kl_pkg::ADR_EVENT) && (ev_cnt_q != 4'h0);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ev_cnt_q <= 4'h0;
			for (int i = 0; i < kl_pkg::EV_DEPTH; i++) begin
				ev_mem_q[i] <= 8'h00;
			end
		end else if (ce) begin
			if (pop) begin
				for (int i = 0; i < kl_pkg::EV_DEPTH - 1; i++) begin
					ev_mem_q[i] <= ev_mem_q[i + 1];
				end
				ev_mem_q[kl_pkg::EV_DEPTH - 1] <= 8'h00;
			end
			if (push && pop) begin
				ev_mem_q[ev_cnt_q - 4'h1] <= ev_byte; // see [RULE_21]
			end else if (push) begin
				ev_mem_q[ev_cnt_q] <= ev_byte;
			end
			if (push && !pop) begin
				ev_cnt_q <= ev_cnt_q + 4'h1;
			end else if (pop && !push) begin
				ev_cnt_q <= ev_cnt_q - 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// port change interrupt
	// ----------------------------------------------------------------
	// the reference follows the pins until synchronisers settle,
	// so the first pin levels after reset do not interrupt
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			init_cnt_q <= 2'h0;
			port_ref_q <= 8'h00;
		end else if (ce) begin
			if (init_cnt_q != 2'(kl_pkg::INIT_CYCLES)) begin
				init_cnt_q <= init_cnt_q + 2'h1;
				port_ref_q <= port_s2_q;
			end else if (hit(rd, bus.addr, kl_pkg::ADR_PORT_DAT)) begin
				port_ref_q <= port_s2_q; // read clears, see [RULE_12]
			end else begin
				// output pins track, so they never interrupt
				port_ref_q <= (port_ref_q & port_dir_q) |
					(port_s2_q & ~port_dir_q); // see [RULE_13]
			end
		end
	end

	// returning to the reference level clears it too
	assign port_irq = |((port_s2_q ^ port_ref_q) & port_dir_q); // see [RULE_12]

	// ----------------------------------------------------------------
	// interrupt pin and release pulse
	// ----------------------------------------------------------------
	assign pending = (int_stat_q[kl_pkg::IST_KEY] &&
			cfg_q[kl_pkg::CFG_KEY_IEN]) ||
		(int_stat_q[kl_pkg::IST_SW] && cfg_q[kl_pkg::CFG_SW_IEN]) ||
		(int_stat_q[kl_pkg::IST_LOCK] && cfg_q[kl_pkg::CFG_LCK_IEN]) ||
		int_stat_q[kl_pkg::IST_THREE] || port_irq;
	// a clear that leaves work pending gives the host a fresh edge
	assign pulse_start = cfg_q[kl_pkg::CFG_INT_PULSE] && int_n_oe_q &&
		((int_stat_q & ist_clr) != 5'h00) &&
		((int_stat_d & ~ist_set) != 5'h00); // see [RULE_15]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulse_cnt_q <= 12'h000;
		end else if (ce) begin
			if (pulse_start) begin
				pulse_cnt_q <= 12'(kl_pkg::PULSE_CYCLES); // see [RULE_15]
			end else if (pulse_cnt_q != 12'h000) begin
				pulse_cnt_q <= pulse_cnt_q - 12'h001;
			end
		end
	end

	// pulling low only while pending and not in a release window
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			int_n_oe_q <= 1'b0;
		end else if (ce) begin
			int_n_oe_q <= pending && !pulse_start &&
				(pulse_cnt_q <= 12'h001); // see [RULE_14]
		end
	end

	// ----------------------------------------------------------------
	// scan mode and oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scan_q <= kl_pkg::KL_SCAN_IDLE;
		end else if (ce) begin
			case (scan_q)
				kl_pkg::KL_SCAN_IDLE: begin
					if (row_s2_q != 8'hff) begin
						scan_q <= kl_pkg::KL_SCAN_ACTIVE; // see [RULE_18]
					end
				end
				kl_pkg::KL_SCAN_ACTIVE: begin
					if (scan_released && row_s2_q == 8'hff) begin
						scan_q <= kl_pkg::KL_SCAN_IDLE; // see [RULE_18]
					end
				end
				default: scan_q <= kl_pkg::KL_SCAN_IDLE;
			endcase
		end
	end

	// idle drives columns low with pulled-up rows, clock only while scanning or while a timer or pulse runs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			col_drive_low_q <= 1'b1;
			row_pullup_q <= 1'b1;
			osc_en_q <= 1'b0;
		end else if (ce) begin
			col_drive_low_q <= (scan_q == kl_pkg::KL_SCAN_IDLE); // see [RULE_17]
			row_pullup_q <= (scan_q == kl_pkg::KL_SCAN_IDLE);
			osc_en_q <= (scan_q == kl_pkg::KL_SCAN_ACTIVE) || timers_on ||
				(pulse_cnt_q != 12'h000); // see [RULE_23]
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// unmapped offsets read as zero; data stands one cycle only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			if (!rd) begin
				rdata_q <= 8'h00;
			end else if (bus.addr == kl_pkg::ADR_CFG) begin
				rdata_q <= cfg_q;
			end else if (bus.addr == kl_pkg::ADR_INT_STAT) begin
				rdata_q <= {3'h0, int_stat_q};
			end else if (bus.addr == kl_pkg::ADR_LOCK_EC) begin
				rdata_q <= {1'b0, lock_en_q, (ul_cnt_q != 3'h0),
					(ul_q == kl_pkg::KL_UL_SECOND), ev_cnt_q};
			end else if (bus.addr == kl_pkg::ADR_EVENT) begin
				rdata_q <= (ev_cnt_q != 4'h0) ? ev_mem_q[0] : 8'h00;
			end else if (bus.addr == kl_pkg::ADR_FIRST_UNLOCK_KEY) begin
				rdata_q <= first_unlock_key_q;
			end else if (bus.addr == kl_pkg::ADR_SECOND_UNLOCK_KEY) begin
				rdata_q <= second_unlock_key_q;
			end else if (bus.addr == kl_pkg::ADR_LOCK_TMR) begin
				rdata_q <= lock_tmr_q;
			end else if (bus.addr == kl_pkg::ADR_SW_GATE) begin
				rdata_q <= {7'h00, sw_gate_q};
			end else if (bus.addr == kl_pkg::ADR_PORT_DAT) begin
				rdata_q <= port_s2_q;
			end else if (bus.addr == kl_pkg::ADR_PORT_DIR) begin
				rdata_q <= port_dir_q;
			end else if (bus.addr == kl_pkg::ADR_SCAN_STAT) begin
				rdata_q <= {5'h00, int_n_oe_q, osc_en_q,
					(scan_q == kl_pkg::KL_SCAN_ACTIVE)};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

endmodule

`default_nettype wire

// >>> rtl/kl_pkg.sv
/*
 * kl_pkg: offsets, fields, reset values, timing and carrier types of the
 * keypad lock and interrupt controller.
 * assumes a single 50 MHz clock domain shared with the register master.
 */
`default_nettype none

package kl_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CFG = 8'h01;
	localparam logic [7:0] ADR_INT_STAT = 8'h02;
	localparam logic [7:0] ADR_LOCK_EC = 8'h03;
	localparam logic [7:0] ADR_EVENT = 8'h04;
	localparam logic [7:0] ADR_FIRST_UNLOCK_KEY = 8'h20;
	localparam logic [7:0] ADR_SECOND_UNLOCK_KEY = 8'h21;
	localparam logic [7:0] ADR_LOCK_TMR = 8'h22;
	localparam logic [7:0] ADR_SW_GATE = 8'h23;
	localparam logic [7:0] ADR_PORT_DAT = 8'h24;
	localparam logic [7:0] ADR_PORT_DIR = 8'h25;
	localparam logic [7:0] ADR_SCAN_STAT = 8'h26;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CFG_INT_PULSE = 4;
	localparam int CFG_LCK_IEN = 2;
	localparam int CFG_SW_IEN = 1;
	localparam int CFG_KEY_IEN = 0;
	localparam int IST_THREE = 4;
	localparam int IST_LOCK = 2;
	localparam int IST_SW = 1;
	localparam int IST_KEY = 0;
	localparam int LEC_LOCK_EN = 6;
	localparam int LEC_TIMING = 5;
	localparam int LEC_FIRST = 4;
	localparam int EV_PRESS = 7;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [4:0] IST_WMASK = 5'h17;

	// ----------------------------------------------------------------
	// event store and fixed three-key combination
	// ----------------------------------------------------------------
	localparam int EV_DEPTH = 10;
	localparam logic [3:0] EV_FULL = 4'ha;
	localparam logic [6:0] KEY_A = 7'h01;
	localparam logic [6:0] KEY_B = 7'h0b;
	localparam logic [6:0] KEY_C = 7'h15;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_PERIOD_NS = 1000000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_US = 50;
	localparam int PULSE_CYCLES = PULSE_US * 1000 / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = 3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic {KL_SCAN_IDLE, KL_SCAN_ACTIVE} kl_scan_t;
	typedef enum logic {KL_UL_FIRST, KL_UL_SECOND} kl_unlock_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kl_bus_t;

	typedef struct packed {
		logic valid;
		logic press;
		logic is_switch;
		logic [6:0] code;
	} kl_event_t;

endpackage

`default_nettype wire

// >>> verif/kl_lock_ctrl_sva.sv
/* kl_lock_ctrl_sva: port assertions of kl_lock_ctrl.
   assumes one clock, ce held high by the bench. */
`default_nettype none
module kl_lock_ctrl_sva #(
	parameter int TICK_CYCLES = 20
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// register port and scanner
	input wire kl_pkg::kl_bus_t bus,
	input wire logic [7:0] rdata_q,
	input wire kl_pkg::kl_event_t key_ev,
	input wire logic scan_released,
	// pins
	input wire logic [7:0] row_pins,
	input wire logic col_drive_low_q,
	input wire logic row_pullup_q,
	input wire logic osc_en_q,
	input wire logic [7:0] port_pins,
	input wire logic int_n_o,
	input wire logic int_n_oe_q
);
	// ----------------
	// sequences
	// ----------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// no key events, so hardware cannot move a bit meanwhile
	sequence s_wr(a);
		ce && bus.wr && bus.addr == a && !key_ev.valid;
	endsequence
	sequence s_rb(a);
		s_wr(a) ##1 ce && !bus.wr && !bus.rd && !key_ev.valid
			##1 ce && bus.rd && bus.addr == a && !key_ev.valid;
	endsequence
	// ----------------
	// assertions
	// ----------------
	AST_PIN_LOW:
		assert property (int_n_oe_q |-> !int_n_o)
		else $error("interrupt pin driven high");
	AST_RST_DFLT:
		assert property ($rose(rstn) |-> col_drive_low_q && row_pullup_q
			&& !osc_en_q && !int_n_oe_q)
		else $error("pins not at defaults after reset");
	AST_ROW_WAKE:
		assert property (ce && col_drive_low_q && row_pins != 8'hff
			|-> ##[1:5] !col_drive_low_q && osc_en_q)
		else $error("low row did not start scanning");
	AST_BACK_IDLE:
		assert property (ce && !col_drive_low_q && scan_released
			&& row_pins == 8'hff |-> ##[1:4] col_drive_low_q)
		else $error("no return to idle scan");
	AST_LOCK_BIT:
		assert property (s_rb(8'h03)
			|=> rdata_q[6] == $past(bus.wdata[6], 3))
		else $error("lock bit read back wrong");
	AST_TIMER_RB:
		assert property (s_rb(8'h22) |=> rdata_q == $past(bus.wdata, 3))
		else $error("timer read back wrong");
	AST_UNLOCK_KEY:
		assert property (s_rb(8'h20)
			|=> rdata_q == {1'b0, $past(bus.wdata[6:0], 3)})
		else $error("unlock key read back wrong");
	AST_UNMAPPED:
		assert property (ce && bus.rd && bus.addr inside {[8'h10:8'h1f]}
			|=> rdata_q == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind kl_lock_ctrl kl_lock_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
	.clock(clock), .rstn(rstn), .ce(ce), .bus(bus), .rdata_q(rdata_q),
	.key_ev(key_ev), .scan_released(scan_released), .row_pins(row_pins),
	.col_drive_low_q(col_drive_low_q), .row_pullup_q(row_pullup_q),
	.osc_en_q(osc_en_q), .port_pins(port_pins), .int_n_o(int_n_o),
	.int_n_oe_q(int_n_oe_q));
`default_nettype wire

// >>> verif/kl_host_model.sv
/* kl_host_model: register master and interrupt receiver.
   assumes its tasks are called right after a rising edge. */
`default_nettype none
module kl_host_model (
	// clock
	input wire logic clock,
	// register port
	output var kl_pkg::kl_bus_t bus,
	input wire logic [7:0] rdata_q,
	// interrupt pin
	input wire logic int_n_o,
	input wire logic int_n_oe_q,
	output wire logic int_line
);
	// ----------------
	// wire and tasks
	// ----------------
	// pull-up holds the line high once released
	assign int_line = int_n_oe_q ? int_n_o : 1'b1;
	initial bus = '0;
	// strobe, then a quiet cycle: transfers never overlap
	task automatic wr(input logic [7:0] a, d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask
	// index first, data taken the cycle after
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		bus <= '0;
		@(negedge clock);
		v = rdata_q;
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

// >>> verif/keypad_lock_and_interrupt_tb_top.sv
/* keypad_lock_and_interrupt_tb_top: directed tests of kl_lock_ctrl.
   assumes kl_host_model drives the register port. */
`default_nettype none
module keypad_lock_and_interrupt_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 20;
	logic clock, rstn, ce, scan_released, col_drive_low_q, row_pullup_q;
	logic osc_en_q, int_n_o, int_n_oe_q;
	logic [7:0] row_pins, port_pins, rdata_q, v;
	logic [7:0] dflt [5] = '{8'h01, 8'h02, 8'h03, 8'h20, 8'h22};
	wire logic int_line;
	kl_pkg::kl_bus_t bus;
	kl_pkg::kl_event_t key_ev;
	int err_count, checks;
	// ----------------
	// parts and helpers
	// ----------------
	always #10 clock = ~clock;
	kl_lock_ctrl #(.TICK_CYCLES(TICK)) i_kl_lock_ctrl (.clock(clock),
		.rstn(rstn), .ce(ce), .bus(bus), .rdata_q(rdata_q), .key_ev(key_ev),
		.scan_released(scan_released), .row_pins(row_pins),
		.col_drive_low_q(col_drive_low_q), .row_pullup_q(row_pullup_q),
		.osc_en_q(osc_en_q), .port_pins(port_pins), .int_n_o(int_n_o),
		.int_n_oe_q(int_n_oe_q));
	kl_host_model i_kl_host_model (.clock(clock), .bus(bus),
		.rdata_q(rdata_q), .int_n_o(int_n_o), .int_n_oe_q(int_n_oe_q),
		.int_line(int_line));
	task automatic chk(input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic w(input logic [7:0] a, d);
		i_kl_host_model.wr(a, d);
	endtask
	// masked read compare
	task automatic rc(input logic [7:0] a, m, e);
		i_kl_host_model.rd(a, v);
		chk(v & m, e);
	endtask
	// one scanner event, then a quiet cycle; codes above 96 are switches
	task automatic key(input logic [6:0] c, input logic p);
		key_ev <= '{valid: 1'b1, press: p, is_switch: c > 7'd96, code: c};
		@(posedge clock);
		key_ev <= '0;
		@(posedge clock);
	endtask
	// {col, pullup, osc, int enable, int wire} mid-cycle
	task automatic pin(input logic [7:0] m, e);
		@(negedge clock);
		chk({3'h0, col_drive_low_q, row_pullup_q, osc_en_q, int_n_oe_q,
			int_line} & m, e);
		@(posedge clock);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------
	// tests
	// ----------------
	// watchdog: whole run is some 3000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		conclude();
	end
	initial begin
		{clock, rstn, ce, scan_released, row_pins} = {4'h3, 8'hff};
		port_pins = 8'h00;
		key_ev = '0;
		{err_count, checks} = 0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		pin(8'h1f, 8'h19);
		foreach (dflt[i]) rc(dflt[i], 8'hff, 8'h00);
		w(8'h22, 8'h51);
		rc(8'h22, 8'hff, 8'h51);
		w(8'h20, 8'h83);
		rc(8'h20, 8'hff, 8'h03);
		w(8'h21, 8'h07);
		w(8'h10, 8'h5a);
		rc(8'h10, 8'hff, 8'h00);
		$display("test registers done");
		w(8'h01, 8'h05);
		key(7'd5, 1'b1);
		key(7'd5, 1'b0);
		pin(8'h03, 8'h02);
		rc(8'h03, 8'h0f, 8'h02);
		rc(8'h04, 8'hff, 8'h85);
		rc(8'h04, 8'hff, 8'h05);
		w(8'h02, 8'h01);
		pin(8'h03, 8'h01);
		$display("test events done");
		w(8'h03, 8'h40);
		rc(8'h03, 8'h40, 8'h40);
		key(7'd9, 1'b1);
		rc(8'h02, 8'h01, 8'h01);
		rc(8'h03, 8'h0f, 8'h00);
		key(7'd3, 1'b1);
		repeat (30) @(posedge clock);
		key(7'd7, 1'b1);
		rc(8'h03, 8'h40, 8'h40);
		key(7'd3, 1'b1);
		rc(8'h03, 8'h10, 8'h10);
		key(7'd7, 1'b1);
		rc(8'h03, 8'h40, 8'h00);
		rc(8'h02, 8'h04, 8'h04);
		w(8'h02, 8'h17);
		w(8'h03, 8'h40);
		key(7'd9, 1'b1);
		w(8'h02, 8'h01);
		key(7'd9, 1'b1);
		rc(8'h02, 8'h01, 8'h00);
		repeat (10 * TICK + 40) @(posedge clock);
		key(7'd9, 1'b1);
		rc(8'h02, 8'h01, 8'h01);
		w(8'h03, 8'h00);
		rc(8'h03, 8'h40, 8'h00);
		w(8'h02, 8'h17);
		$display("test lock done");
		w(8'h03, 8'h40);
		key(7'd97, 1'b1);
		w(8'h23, 8'h01);
		key(7'd98, 1'b1);
		rc(8'h03, 8'h0f, 8'h01);
		w(8'h03, 8'h00);
		rc(8'h04, 8'hff, 8'he1);
		w(8'h02, 8'h17);
		$display("test switch gating done");
		w(8'h01, 8'h11);
		key(7'd1, 1'b1);
		key(7'd11, 1'b1);
		rc(8'h02, 8'h10, 8'h00);
		key(7'd21, 1'b1);
		rc(8'h02, 8'h10, 8'h10);
		key(7'd5, 1'b1);
		w(8'h02, 8'h01);
		repeat (3) @(posedge clock);
		pin(8'h03, 8'h01);
		repeat (2500) @(posedge clock);
		pin(8'h03, 8'h02);
		w(8'h02, 8'h17);
		$display("test pulse done");
		w(8'h25, 8'h01);
		port_pins <= 8'h02;
		repeat (6) @(posedge clock);
		pin(8'h03, 8'h01);
		port_pins <= 8'h03;
		repeat (6) @(posedge clock);
		pin(8'h03, 8'h02);
		port_pins <= 8'h02;
		repeat (6) @(posedge clock);
		pin(8'h03, 8'h01);
		port_pins <= 8'h03;
		repeat (6) @(posedge clock);
		rc(8'h24, 8'h01, 8'h01);
		pin(8'h03, 8'h01);
		row_pins <= 8'hfb;
		scan_released <= 1'b0;
		repeat (6) @(posedge clock);
		pin(8'h14, 8'h04);
		row_pins <= 8'hff;
		scan_released <= 1'b1;
		repeat (8) @(posedge clock);
		pin(8'h1c, 8'h18);
		$display("test port and scan done");
		conclude();
	end
endmodule
`default_nettype wire
